// ==== iod_pkg.sv ====
// Shared constants and carrier types for the inertial output data register bank
package iod_pkg;

  // ************************************************
  // Widths
  // ************************************************
  localparam int WORD_W     = 16;
  localparam int AXIS_W     = 32;
  localparam int NUM_AXES   = 3;
  localparam int NUM_WORDS  = 12;
  localparam int IDX_W      = 4;
  localparam int ADDR_W     = 7;
  localparam int FRAME_BITS = 16;
  localparam int CNT_W      = 4;

  // ************************************************
  // Byte offsets on page 0
  // ************************************************
  localparam logic [6:0] OFF_PAGE_SELECT = 7'h00;
  localparam logic [6:0] OFF_X_RATE_LO   = 7'h10;
  localparam logic [6:0] OFF_X_RATE_HI   = 7'h12;
  localparam logic [6:0] OFF_Y_RATE_LO   = 7'h14;
  localparam logic [6:0] OFF_Y_RATE_HI   = 7'h16;
  localparam logic [6:0] OFF_Z_RATE_LO   = 7'h18;
  localparam logic [6:0] OFF_Z_RATE_HI   = 7'h1a;
  localparam logic [6:0] OFF_X_ACCEL_LO  = 7'h1c;
  localparam logic [6:0] OFF_X_ACCEL_HI  = 7'h1e;
  localparam logic [6:0] OFF_Y_ACCEL_LO  = 7'h20;
  localparam logic [6:0] OFF_Y_ACCEL_HI  = 7'h22;
  localparam logic [6:0] OFF_Z_ACCEL_LO  = 7'h24;
  localparam logic [6:0] OFF_Z_ACCEL_HI  = 7'h26;
  localparam logic [6:0] OFF_DATA_FIRST  = OFF_X_RATE_LO;
  localparam logic [6:0] OFF_DATA_LAST   = 7'h27;

  // ************************************************
  // Reset values and the data page number
  // ************************************************
  localparam logic [7:0]  PAGE_RESET = 8'h00;
  localparam logic [7:0]  PAGE_DATA  = 8'h00;
  localparam logic [15:0] WORD_ZERO  = 16'h0000;

  // ************************************************
  // Types
  // ************************************************
  typedef logic [AXIS_W-1:0] iod_axis_t;

  typedef struct packed {
    iod_axis_t [NUM_AXES-1:0] accel;
    iod_axis_t [NUM_AXES-1:0] rate;
  } iod_sample_s;

  typedef struct packed {
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
  } iod_cmd_s;

  typedef enum logic [1:0] {
    SEL_ZERO,
    SEL_PAGE,
    SEL_MEM
  } iod_sel_e;

  function automatic logic [IDX_W-1:0] word_idx(input logic [ADDR_W-1:0] off);
    logic [ADDR_W-1:0] rel;
    rel = off - OFF_DATA_FIRST;
    return rel[IDX_W:1];
  endfunction

endpackage

// ==== iod_word_mem.sv ====
// Word memory holding the output data, written whole, read through a register
`timescale 1ns/100ps
module iod_word_mem #(
  parameter int WORDS = 12,
  parameter int W     = 16,
  parameter int IW    = 4
) (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic                      ce,
  input  wire logic                      wr_en,
  input  wire logic [WORDS-1:0][W-1:0]   wr_data,
  input  wire logic                      rd_en,
  input  wire logic [IW-1:0]             rd_idx,
  output logic      [W-1:0]              rd_data
);

  if (WORDS > (1 << IW) || WORDS < 1) begin : g_chk
    $error("iod_word_mem: WORDS does not fit the index width");
  end

  logic [WORDS-1:0][W-1:0] mem_ff;

  // ************************************************
  // Storage, every entry loaded in the same cycle
  // ************************************************
  for (genvar i = 0; i < WORDS; i++) begin : g_word
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        mem_ff[i] <= '0;
      end else if (ce && wr_en) begin
        mem_ff[i] <= wr_data[i];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= '0;
    end else if (ce && rd_en) begin
      rd_data <= (int'(rd_idx) < WORDS) ? mem_ff[rd_idx] : '0;
    end
  end

endmodule

// ==== iod_regbank.sv ====
// Serial-read output data register bank with page select
//
// Operation
// - The page select value is zero after reset so page 0 is addressed.
// - Page 0 holds the output data registers, other pages read them as zero.
// - Each rate and acceleration axis is a 32-bit two's complement value in two words.
// - The upper word holds bits 31..16 and the lower word bits 15..0.
// - Rate upper words are two's complement at 0.025 deg/s per LSB, span +-450 deg/s.
// - Rate lower words extend resolution, top bit 0.0125 deg/s, each next bit half.
// - Accel upper words are two's complement at 1 mg per LSB, span +-20 g.
// - Accel lower words extend resolution, top bit 0.5 mg, each next bit half.
// - Rate upper words of X, Y and Z sit at 0x12, 0x16 and 0x1a.
// - Rate lower words of X, Y and Z sit at 0x10, 0x14 and 0x18.
// - Accel upper words of Y and Z sit at 0x22 and 0x26, X upper just below Y lower.
// - All sixteen bits of a rate lower word are extra resolution bits.
// - All sixteen bits of an accel lower word are extra resolution bits.
// - A read takes two 16-bit frames, request in the first, data out in the second.
`timescale 1ns/100ps
module iod_regbank (
  input  wire logic                 CLOCK,
  input  wire logic                 RST_N,
  input  wire logic                 CE,
  input  wire logic                 SAMPLE_VALID,
  input  wire iod_pkg::iod_sample_s SAMPLE,
  input  wire logic                 SCLK,
  input  wire logic                 CS_N,
  input  wire logic                 DIN,
  output logic                      DOUT,
  output logic                      DOUT_OE,
  output logic [7:0]                PAGE_SELECT
);

  // ************************************************
  // Declarations
  // ************************************************
  logic                                   rst_meta_ff;
  logic                                   rst_n_ff;
  logic                                   lnk_clr_n;
  logic [iod_pkg::CNT_W-1:0]              bit_cnt_ff;
  logic [iod_pkg::FRAME_BITS-2:0]         in_sh_ff;
  logic [iod_pkg::FRAME_BITS-1:0]         cmd_word_ff;
  logic                                   req_tgl_ff;
  logic [iod_pkg::FRAME_BITS-2:0]         out_sh_ff;
  logic                                   tgl_meta_ff;
  logic                                   tgl_sync_ff;
  logic                                   tgl_seen_ff;
  logic                                   req_evt;
  iod_pkg::iod_cmd_s                      cmd;
  logic                                   is_page;
  logic                                   is_data;
  logic                                   page_we;
  logic                                   rd_en;
  logic [iod_pkg::IDX_W-1:0]              rd_idx;
  logic [iod_pkg::WORD_W-1:0]             rd_data;
  logic                                   sample_we;
  logic [iod_pkg::NUM_WORDS-1:0][15:0]    wr_words;
  iod_pkg::iod_sel_e                      sel_ff;
  logic                                   pend_ff;
  logic [iod_pkg::WORD_W-1:0]             resp_ff;
  logic [7:0]                             page_ff;

  // ************************************************
  // Reset release
  // ************************************************
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff    <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff    <= rst_meta_ff;
    end
  end

  // ************************************************
  // Link side, clocked by SCLK
  // ************************************************
  // Frame state ends with the frame; SCLK stops between frames
  assign lnk_clr_n = ~CS_N & rst_n_ff;

  always_ff @(posedge SCLK or negedge lnk_clr_n) begin
    if (!lnk_clr_n) begin
      bit_cnt_ff <= '0;
      in_sh_ff   <= '0;
    end else begin
      bit_cnt_ff <= bit_cnt_ff + 1'b1;
      in_sh_ff   <= {in_sh_ff[iod_pkg::FRAME_BITS-3:0], DIN};
    end
  end

  // full 16 clocks needed before a request counts
  always_ff @(posedge SCLK or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      cmd_word_ff <= '0;
      req_tgl_ff  <= 1'b0;
    end else if (bit_cnt_ff == iod_pkg::CNT_W'(iod_pkg::FRAME_BITS - 1)) begin
      cmd_word_ff <= {in_sh_ff, DIN};
      req_tgl_ff  <= ~req_tgl_ff;
    end
  end

  // answer shifted out MSB first on falling edges
  // Response word is held static by the core long before the next frame
  always_ff @(negedge SCLK or negedge lnk_clr_n) begin
    if (!lnk_clr_n) begin
      DOUT      <= 1'b0;
      DOUT_OE   <= 1'b0;
      out_sh_ff <= '0;
    end else if (!DOUT_OE) begin
      DOUT      <= resp_ff[iod_pkg::WORD_W-1];
      DOUT_OE   <= 1'b1;
      out_sh_ff <= resp_ff[iod_pkg::WORD_W-2:0];
    end else begin
      DOUT      <= out_sh_ff[iod_pkg::FRAME_BITS-2];
      out_sh_ff <= {out_sh_ff[iod_pkg::FRAME_BITS-3:0], 1'b0};
    end
  end

  // ************************************************
  // Request crossing into the core clock
  // ************************************************
  always_ff @(posedge CLOCK or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      tgl_meta_ff <= 1'b0;
      tgl_sync_ff <= 1'b0;
      tgl_seen_ff <= 1'b0;
    end else if (CE) begin
      tgl_meta_ff <= req_tgl_ff;
      tgl_sync_ff <= tgl_meta_ff;
      tgl_seen_ff <= tgl_sync_ff;
    end
  end

  // Command word is stable from the toggle until the next frame ends
  assign req_evt = CE & (tgl_sync_ff ^ tgl_seen_ff);
  assign cmd     = iod_pkg::iod_cmd_s'(cmd_word_ff);
  assign is_page = (cmd.addr[6:1] == iod_pkg::OFF_PAGE_SELECT[6:1]);
  assign is_data = (cmd.addr >= iod_pkg::OFF_DATA_FIRST) &&
                   (cmd.addr <= iod_pkg::OFF_DATA_LAST);

  // ************************************************
  // Page select
  // ************************************************
  // Only the low byte is writable; the high byte reads zero
  assign page_we = req_evt & cmd.wr & is_page & ~cmd.addr[0];

  always_ff @(posedge CLOCK or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      page_ff <= iod_pkg::PAGE_RESET;
    end else if (page_we) begin
      page_ff <= cmd.data;
    end
  end

  always_ff @(posedge CLOCK or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      PAGE_SELECT <= iod_pkg::PAGE_RESET;
    end else if (CE) begin
      PAGE_SELECT <= page_ff;
    end
  end

  // ************************************************
  // Sample capture
  // ************************************************
  assign sample_we = CE & SAMPLE_VALID;

  // upper word bits 31..16, lower 15..0
  for (genvar a = 0; a < iod_pkg::NUM_AXES; a++) begin : g_axis
    // rate lower word, all sixteen bits
    assign wr_words[2*a]     = SAMPLE.rate[a][15:0];
    assign wr_words[2*a+1]   = SAMPLE.rate[a][31:16];
    // accel lower word, all sixteen bits
    assign wr_words[2*a+6]   = SAMPLE.accel[a][15:0];
    assign wr_words[2*a+7]   = SAMPLE.accel[a][31:16];
  end

  // one write loads every word from one sample
  iod_word_mem #(
    .WORDS (iod_pkg::NUM_WORDS),
    .W     (iod_pkg::WORD_W),
    .IW    (iod_pkg::IDX_W)
  ) u_mem (
    .clk     (CLOCK),
    .rst_n   (rst_n_ff),
    .ce      (CE),
    .wr_en   (sample_we),
    .wr_data (wr_words),
    .rd_en   (rd_en),
    .rd_idx  (rd_idx),
    .rd_data (rd_data)
  );

  // ************************************************
  // Read decode and answer word
  // ************************************************
  // write commands never reach the memory
  assign rd_en  = req_evt & ~cmd.wr & is_data & (page_ff == iod_pkg::PAGE_DATA);
  assign rd_idx = iod_pkg::word_idx(cmd.addr);

  // data visible on page 0 only
  always_ff @(posedge CLOCK or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      sel_ff  <= iod_pkg::SEL_ZERO;
      pend_ff <= 1'b0;
    end else if (CE) begin
      pend_ff <= req_evt;
      if (req_evt) begin
        if (rd_en) begin
          sel_ff <= iod_pkg::SEL_MEM;
        end else if (!cmd.wr && is_page) begin
          sel_ff <= iod_pkg::SEL_PAGE;
        end else begin
          sel_ff <= iod_pkg::SEL_ZERO;
        end
      end
    end
  end

  // answer ready for the next frame
  always_ff @(posedge CLOCK or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      resp_ff <= iod_pkg::WORD_ZERO;
    end else if (CE && pend_ff) begin
      unique case (sel_ff)
        iod_pkg::SEL_MEM:  resp_ff <= rd_data;
        iod_pkg::SEL_PAGE: resp_ff <= {8'h00, page_ff};
        iod_pkg::SEL_ZERO: resp_ff <= iod_pkg::WORD_ZERO;
        default:           resp_ff <= iod_pkg::WORD_ZERO;
      endcase
    end
  end

  // ************************************************
  // Assertions
  // ************************************************
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!rst_n_ff);

  property p_page_reset;
    $rose(rst_n_ff) |-> page_ff == iod_pkg::PAGE_RESET;
  endproperty
  a_page_reset: assert property (p_page_reset) else $error("page not zero after reset");

  property p_page_write;
    page_we |=> page_ff == $past(cmd.data);
  endproperty
  a_page_write: assert property (p_page_write) else $error("page write lost");

  property p_off_page;
    req_evt && !cmd.wr && is_data && page_ff != iod_pkg::PAGE_DATA |-> ##2 resp_ff == iod_pkg::WORD_ZERO;
  endproperty
  a_off_page: assert property (p_off_page) else $error("data seen off page 0");

  property p_rate_x;
    sample_we |=> {u_mem.mem_ff[iod_pkg::word_idx(iod_pkg::OFF_X_RATE_HI)],
                   u_mem.mem_ff[iod_pkg::word_idx(iod_pkg::OFF_X_RATE_LO)]} == $past(SAMPLE.rate[0]);
  endproperty
  a_rate_x: assert property (p_rate_x) else $error("x rate pair not coherent");

  property p_rate_z_hi;
    sample_we |=> u_mem.mem_ff[iod_pkg::word_idx(iod_pkg::OFF_Z_RATE_HI)] == $past(SAMPLE.rate[2][31:16]);
  endproperty
  a_rate_z_hi: assert property (p_rate_z_hi) else $error("z rate upper word wrong");

  property p_rate_y_lo;
    sample_we |=> u_mem.mem_ff[iod_pkg::word_idx(iod_pkg::OFF_Y_RATE_LO)] == $past(SAMPLE.rate[1][15:0]);
  endproperty
  a_rate_y_lo: assert property (p_rate_y_lo) else $error("y rate lower word wrong");

  property p_accel_hi;
    sample_we |=> u_mem.mem_ff[iod_pkg::word_idx(iod_pkg::OFF_Y_ACCEL_HI)] == $past(SAMPLE.accel[1][31:16])
              && u_mem.mem_ff[iod_pkg::word_idx(iod_pkg::OFF_Y_ACCEL_LO) - 1'b1]
                 == $past(SAMPLE.accel[0][31:16]);
  endproperty
  a_accel_hi: assert property (p_accel_hi) else $error("accel upper word misplaced");

  property p_accel_z_lo;
    sample_we |=> u_mem.mem_ff[iod_pkg::word_idx(iod_pkg::OFF_Z_ACCEL_LO)] == $past(SAMPLE.accel[2][15:0]);
  endproperty
  a_accel_z_lo: assert property (p_accel_z_lo) else $error("z accel lower word wrong");

  property p_read_page;
    req_evt && !cmd.wr && is_page |-> ##2 resp_ff == {8'h00, $past(page_ff, 2)};
  endproperty
  a_read_page: assert property (p_read_page) else $error("page read answer wrong");

  property p_read_data;
    rd_en && !sample_we ##1 !sample_we |-> ##1 resp_ff == u_mem.mem_ff[$past(rd_idx, 2)];
  endproperty
  a_read_data: assert property (p_read_data) else $error("data read answer wrong");

  property p_no_write;
    req_evt && cmd.wr && !sample_we |=> u_mem.mem_ff == $past(u_mem.mem_ff);
  endproperty
  a_no_write: assert property (p_no_write) else $error("host write changed data");

  property p_rate_y_hi;
    sample_we |=> u_mem.mem_ff[iod_pkg::word_idx(iod_pkg::OFF_Y_RATE_HI)] == $past(SAMPLE.rate[1][31:16]);
  endproperty
  a_rate_y_hi: assert property (p_rate_y_hi) else $error("y rate upper word wrong");

  property p_rate_z_lo;
    sample_we |=> u_mem.mem_ff[iod_pkg::word_idx(iod_pkg::OFF_Z_RATE_LO)] == $past(SAMPLE.rate[2][15:0]);
  endproperty
  a_rate_z_lo: assert property (p_rate_z_lo) else $error("z rate lower word wrong");

  property p_accel_x_lo;
    sample_we |=> u_mem.mem_ff[iod_pkg::word_idx(iod_pkg::OFF_X_ACCEL_LO)] == $past(SAMPLE.accel[0][15:0]);
  endproperty
  a_accel_x_lo: assert property (p_accel_x_lo) else $error("x accel lower word wrong");

  property p_accel_z_hi;
    sample_we |=> u_mem.mem_ff[iod_pkg::word_idx(iod_pkg::OFF_Z_ACCEL_HI)] == $past(SAMPLE.accel[2][31:16]);
  endproperty
  a_accel_z_hi: assert property (p_accel_z_hi) else $error("z accel upper word wrong");

  property p_page_out;
    CE |=> PAGE_SELECT == $past(page_ff);
  endproperty
  a_page_out: assert property (p_page_out) else $error("page select output stale");

  property p_dout_idle;
    CS_N |-> !DOUT_OE;
  endproperty
  a_dout_idle: assert property (p_dout_idle) else $error("data output driven while deselected");

  c_read_data: cover property (rd_en ##2 pend_ff == 1'b0);
  c_page_write: cover property (page_we ##1 page_ff != iod_pkg::PAGE_DATA);
  c_read_page: cover property (req_evt && !cmd.wr && is_page);
  c_sample_then_read: cover property (sample_we ##[1:200] rd_en);

endmodule

// ==== iod_spi_host.sv ====
// Serial host model driving 16-bit mode 3 frames into the register bank
`timescale 1ns/100ps
module iod_spi_host (
  output logic      sclk,
  output logic      cs_n,
  output logic      din,
  input  wire logic dout,
  input  wire logic dout_oe
);
  // Stall after each frame, raised by the bench for slow hosts
  int gap_ns = 2000;

  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din  = 1'b1;
  end

  // ************************************************
  // Frame
  // ************************************************
  // request MSB first, answer on rise
  task automatic xfer(input logic [15:0] cmd, output logic [15:0] rsp);
    cs_n = 1'b0;
    #32;
    for (int i = 15; i >= 0; i--) begin
      sclk   = 1'b0;
      din    = cmd[i];
      #7.5;
      sclk   = 1'b1;
      // Undriven line reads as unknown
      rsp[i] = dout_oe ? dout : 1'bx;
      #7.5;
    end
    #32;
    cs_n = 1'b1;
    // Released line must not look like a held bit
    din  = ~din;
    #(gap_ns);
  endtask
endmodule

// ==== test_iod_regbank.sv ====
// Self-checking bench for the output data register bank
`timescale 1ns/100ps
module test_iod_regbank;
  logic                 clock        = 1'b0;
  logic                 rst_n        = 1'b0;
  logic                 ce           = 1'b1;
  logic                 sample_valid = 1'b0;
  iod_pkg::iod_sample_s sample       = '0;
  iod_pkg::iod_sample_s s0;
  iod_pkg::iod_sample_s s1;
  wire                  sclk;
  wire                  cs_n;
  wire                  din;
  wire                  dout;
  wire                  dout_oe;
  logic [7:0]           page_select;
  int                   n_fail       = 0;
  int                   tests_run    = 0;

  iod_regbank dut_u (
    .CLOCK        (clock),
    .RST_N        (rst_n),
    .CE           (ce),
    .SAMPLE_VALID (sample_valid),
    .SAMPLE       (sample),
    .SCLK         (sclk),
    .CS_N         (cs_n),
    .DIN          (din),
    .DOUT         (dout),
    .DOUT_OE      (dout_oe),
    .PAGE_SELECT  (page_select)
  );

  iod_spi_host host_u (
    .sclk    (sclk),
    .cs_n    (cs_n),
    .din     (din),
    .dout    (dout),
    .dout_oe (dout_oe)
  );

  initial begin
    forever #20 clock = ~clock;
  end

  // ************************************************
  // Tasks
  // ************************************************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic rd(input logic [6:0] addr, input logic [15:0] exp);
    logic [15:0] junk;
    logic [15:0] data;
    host_u.xfer({1'b0, addr, 8'h00}, junk);
    host_u.xfer(16'h0000, data);
    chk(data, exp);
  endtask

  task automatic wr(input logic [6:0] addr, input logic [7:0] val);
    logic [15:0] junk;
    host_u.xfer({1'b1, addr, val}, junk);
    host_u.xfer(16'h0000, junk);
    chk(junk, 16'h0000);
  endtask

  task automatic load(input iod_pkg::iod_sample_s s);
    @(posedge clock);
    sample       <= s;
    sample_valid <= 1'b1;
    @(posedge clock);
    sample_valid <= 1'b0;
  endtask

  // Word w counts from the X rate lower word upwards
  function automatic logic [15:0] exp_word(iod_pkg::iod_sample_s s, int w);
    logic [31:0] v;
    v = (w < 6) ? s.rate[w / 2] : s.accel[w / 2 - 3];
    return w[0] ? v[31:16] : v[15:0];
  endfunction

  task automatic test_done;
    $display("counts: %0d compared, %0d mismatched", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ************************************************
  // Watchdog
  // ************************************************
  // Whole sequence needs well under 300 us
  initial begin
    #1ms;
    n_fail++;
    $display("unexpected at %0t: run did not finish", $time);
    test_done;
  end

  // ************************************************
  // Sequence
  // ************************************************
  initial begin
    // Full-scale and half-LSB corners of both scalings
    s0.rate  = {32'hffff_ffff, 32'hb9b0_0001, 32'h4650_8000};
    s0.accel = {32'h0001_7fff, 32'hb1e0_ffff, 32'h4e20_0000};
    s1       = ~s0;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    chk({8'h00, page_select}, 16'h0000);
    chk({15'h0000, dout_oe}, 16'h0000);
    rd(7'h00, 16'h0000);
    rd(7'h12, 16'h0000);
    $display("test reset done");

    load(s0);
    for (int j = 0; j < 24; j++) begin
      rd(7'h10 + j[6:0], exp_word(s0, j / 2));
    end
    $display("test map done");

    wr(7'h12, 8'hab);
    rd(7'h12, exp_word(s0, 1));
    @(posedge clock);
    ce <= 1'b0;
    load(s1);
    @(posedge clock);
    ce <= 1'b1;
    rd(7'h10, exp_word(s0, 0));
    load(s1);
    rd(7'h1c, exp_word(s1, 6));
    rd(7'h1e, exp_word(s1, 7));
    $display("test sample done");

    wr(7'h00, 8'h03);
    chk({8'h00, page_select}, 16'h0003);
    rd(7'h12, 16'h0000);
    wr(7'h01, 8'h55);
    rd(7'h00, 16'h0003);
    host_u.gap_ns = 5000;
    wr(7'h00, 8'h00);
    rd(7'h12, exp_word(s1, 1));
    rd(7'h28, 16'h0000);
    rd(7'h0e, 16'h0000);
    host_u.gap_ns = 2000;
    $display("test page done");

    wr(7'h00, 8'h05);
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    chk({8'h00, page_select}, 16'h0000);
    rd(7'h00, 16'h0000);
    rd(7'h26, 16'h0000);
    $display("test second reset done");
    test_done;
  end
endmodule
